//--- dv/flkc_flash_model.sv
// flkc_flash_model: behavioural flash, lock-bits and status word only.
// assumes a command is taken when a selected write strobe ends.
`timescale 1ns/1ps
module flkc_flash_model #(
	parameter int BUSY_NS = 400
) (
	// bus pins
	input  wire logic        ce_n, we_n, oe_n,
	input  wire logic [19:0] addr,
	input  wire logic [15:0] dq_w,
	output logic      [15:0] dq_r
);
	// ====
	// lock state; reserved bits read as one so masking is exercised
	logic [7:0]  sts = 8'h89;
	logic [15:0] blk = 16'h0, last_v = 16'h0; // lock-bits bar erase and write
	logic        perm = 1'b0, setup = 1'b0, st_mode = 1'b0;
	// a write ends when either enable rises; both may rise in one time step
	logic        wr_sel;
	assign wr_sel = !ce_n && !we_n;
	// refusals answer at once, real work answers slowly
	task automatic work();
		sts[7] = 1'b0;
		fork
			#(BUSY_NS) sts[7] = 1'b1;
		join_none
	endtask
	always @(negedge wr_sel) begin
		if (setup) begin
			setup = 1'b0;
			st_mode = 1'b1;
			case (dq_w[7:0])
			8'h01: if (perm) sts = sts | 8'h12;
				else blk[addr[19:16]] = 1'b1;
			8'hf1: perm = 1'b1;
			8'hd0: if (perm) sts = sts | 8'h22;
				else blk = 16'h0;
			default: sts = sts | 8'h30;
			endcase
			if (sts[1] == 1'b0)
				work();
		end else begin
			case (dq_w[7:0])
			8'h60: setup = 1'b1;
			8'h70: st_mode = 1'b1;
			8'h50: sts = sts & 8'hcd;
			8'hff: st_mode = 1'b0;
			default: ;
			endcase
		end
	end
	// released bus shows the inverse of the last word
	always @(dq_r) if (!ce_n && !oe_n) last_v = dq_r;
	assign dq_r = (!ce_n && !oe_n) ? (st_mode ? {8'h0, sts} : 16'hffff) : ~last_v;
endmodule

//--- dv/flkc_host_assertions.sv
// flkc_host_assertions: port checks for the lock-bit host controller.
// assumes one clock domain and the sync active-low reset.
`timescale 1ns/1ps
module flkc_host_assertions (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// local register port
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// flash pins
	input wire logic [19:0] fl_addr,
	input wire logic [15:0] dq_out,
	input wire logic        dq_oe,
	input wire logic [15:0] dq_in,
	input wire logic        ce_n,
	input wire logic        we_n,
	input wire logic        oe_n
);
	// ====
	// pin and register checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_we_inside_ce: assert property (!we_n |-> !ce_n)
		else $error("write strobe without select");
	a_write_drives: assert property (!we_n |-> dq_oe && oe_n)
		else $error("write strobe with bus released");
	a_read_released: assert property (!oe_n |-> we_n && !dq_oe)
		else $error("bus driven during read");
	a_pulse_width: assert property ($fell(we_n) |-> !we_n[*6] ##1 we_n)
		else $error("write pulse length off");
	a_cmd_stable: assert property (!we_n && !$past(we_n) |-> $stable(dq_out) && $stable(fl_addr))
		else $error("command moved in pulse");
	a_confirm_code: assert property ($rose(we_n) && dq_out[7:0] == 8'h60 |->
		##[1:12] $fell(we_n) && dq_out[7:0] inside {8'h01, 8'hf1, 8'hd0})
		else $error("setup not followed by confirm");
	a_result_masked: assert property (reg_rd && reg_addr == 4'h3 |=> !reg_rdata[3] && !reg_rdata[0])
		else $error("reserved status bits leak");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	c_perm: cover property ($fell(we_n) && dq_out[7:0] == 8'hf1);
	c_clear: cover property ($fell(we_n) && dq_out[7:0] == 8'hd0);
	c_read: cover property ($fell(oe_n));
endmodule
bind flkc_host flkc_host_assertions chk (
	.clk       (clk),
	.rst_n     (rst_n),
	.reg_addr  (reg_addr),
	.reg_wdata (reg_wdata),
	.reg_wr    (reg_wr),
	.reg_rd    (reg_rd),
	.reg_rdata (reg_rdata),
	.fl_addr   (fl_addr),
	.dq_out    (dq_out),
	.dq_oe     (dq_oe),
	.dq_in     (dq_in),
	.ce_n      (ce_n),
	.we_n      (we_n),
	.oe_n      (oe_n)
);

//--- dv/flkc_host_tb.sv
// flkc_host_tb: drives the register port and judges flash command results.
// assumes the behavioural flash model on the pins.
`timescale 1ns/1ps
module flkc_host_tb;
	logic        clk, rst_n, reg_wr, reg_rd, dq_oe, ce_n, we_n, oe_n;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, r;
	logic [19:0] fl_addr;
	logic [15:0] dq_out, dq_in;
	int          n_fail = 0, num_checks = 0, cyc = 0;
	flkc_host DUT (
		.clk       (clk),
		.rst_n     (rst_n),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.fl_addr   (fl_addr),
		.dq_out    (dq_out),
		.dq_oe     (dq_oe),
		.dq_in     (dq_in),
		.ce_n      (ce_n),
		.we_n      (we_n),
		.oe_n      (oe_n)
	);
	flkc_flash_model fm (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(fl_addr),
		.dq_w(dq_oe ? dq_out : 16'hzzzz), .dq_r(dq_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// start an op, poll busy under a bound, return the status byte
	task automatic run_op(logic [2:0] op, logic [19:0] a);
		wr(flkc_pkg::REG_ADDR, {12'h0, a});
		wr(flkc_pkg::REG_CTRL, {29'h0, op});
		r = 32'h1;
		for (int i = 0; i < 400 && r[0]; i++) rd(flkc_pkg::REG_STATUS, r);
		chk("done", 32'h2, r);
		rd(flkc_pkg::REG_RESULT, r);
		r = r & 32'hff;
	endtask
	task automatic t_open_locks();
		run_op(3'h1, 20'h30000);
		chk("set block", 32'h80, r);
		chk("block bits", 32'h8, {16'h0, fm.blk});
		chk("status mode", 32'h1, {31'h0, fm.st_mode});
		rd(flkc_pkg::REG_ADDR, r);
		chk("addr reg", 32'h30000, r);
		rd(flkc_pkg::REG_CTRL, r);
		chk("ctrl reg", 32'h1, r);
		run_op(3'h3, 20'h0);
		chk("clear", 32'h80, r);
		chk("block bits", 32'h0, {16'h0, fm.blk});
	endtask
	task automatic t_perm_refusals();
		run_op(3'h2, 20'h10);
		chk("set perm", 32'h80, r);
		run_op(3'h1, 20'h50000);
		chk("locked set", 32'h92, r);
		run_op(3'h3, 20'h0);
		chk("locked clear", 32'hb2, r);
		chk("perm bit", 32'h1, {31'h0, fm.perm});
	endtask
	task automatic t_clear_and_array();
		run_op(3'h4, 20'h0);
		run_op(3'h6, 20'h0);
		chk("cleared", 32'h80, r);
		run_op(3'h5, 20'h0);
		chk("array mode", 32'h0, {31'h0, fm.st_mode});
		rd(4'hf, r);
		chk("unmapped", 32'h0, r);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_open_locks();
		t_perm_refusals();
		t_clear_and_array();
		tally_and_finish();
	end
endmodule

//--- logic/flkc_host.sv
// flkc_host: host-side controller issuing lock-bit configuration sequences
// to a boot-block flash and polling operation_status.
// assumes the flash bus pins connect directly; data pins are tristated
// by the bench from dq_out/dq_oe.
// assumes software polls STATUS for busy low before each new order.
//
// Contract
// - set lock: write 60h then 01h at block or f1h anywhere.
// - host ignores bits 6..0 while bit 7 reads zero.
// - host masks reserved bits 3 and 0.
// - host writes 70h to read status, ffh to return to array.
// - command written only with chip enable and write enable both low.
`timescale 1ns/1ps
module flkc_host (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// local register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// flash pins
	output logic      [19:0] fl_addr,
	output logic      [15:0] dq_out,
	output logic             dq_oe,
	input  wire logic [15:0] dq_in,
	output logic             ce_n,
	output logic             we_n,
	output logic             oe_n
);
	typedef enum {
		S_IDLE, S_WR_ASSERT, S_WR_GAP, S_RD_ASSERT, S_RD_GAP, S_DECIDE
	} flkc_state_t;

	// sequencer, orders from software and the outcome
	flkc_state_t state;
	logic [2:0]  op;
	logic        busy;
	logic        done;
	logic        timeout;
	logic [19:0] target;
	logic [7:0]  result;
	logic [1:0]  step;
	logic [3:0]  tcnt;
	logic [15:0] polls;
	// pin data after the synchroniser, and the byte being written
	logic [7:0]  dq_sync;
	logic [7:0]  cmd_byte;
	logic        start;

	// only the status byte is ever read back
	flkc_sync #(.W(8)) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (dq_in[7:0]),
		.sync_out (dq_sync)
	);

	// ==========================================
	// sequence table: command byte for each step of each operation
	function automatic logic [7:0] seq_byte(input logic [2:0] o, input logic [1:0] s);
		logic [7:0] b;
		b = flkc_pkg::CMD_READ_STATUS;
		case (o)
			flkc_pkg::OP_SET_BLOCK: b = (s == 2'd0) ? flkc_pkg::CMD_LOCK_SETUP
			                                        : flkc_pkg::CMD_BLOCK_CONF;
			flkc_pkg::OP_SET_PERM:  b = (s == 2'd0) ? flkc_pkg::CMD_LOCK_SETUP
			                                        : flkc_pkg::CMD_PERM_CONF;
			flkc_pkg::OP_CLEAR:     b = (s == 2'd0) ? flkc_pkg::CMD_LOCK_SETUP
			                                        : flkc_pkg::CMD_CLEAR_CONF;
			flkc_pkg::OP_CLR_STAT:  b = flkc_pkg::CMD_CLEAR_STATUS;
			flkc_pkg::OP_ARRAY:     b = flkc_pkg::CMD_READ_ARRAY;
			flkc_pkg::OP_POLL:      b = flkc_pkg::CMD_READ_STATUS;
			default:                b = flkc_pkg::CMD_READ_STATUS;
		endcase
		return b;
	endfunction

	// number of command writes before status polling
	function automatic logic [1:0] seq_len(input logic [2:0] o);
		case (o)
			flkc_pkg::OP_SET_BLOCK, flkc_pkg::OP_SET_PERM, flkc_pkg::OP_CLEAR: return 2'd2;
			default: return 2'd1;
		endcase
	endfunction

	// does this operation wait on ready before finishing
	function automatic logic seq_polls(input logic [2:0] o);
		return (o == flkc_pkg::OP_SET_BLOCK) || (o == flkc_pkg::OP_SET_PERM)
		    || (o == flkc_pkg::OP_CLEAR) || (o == flkc_pkg::OP_POLL);
	endfunction

	// true on the last command write of an operation
	function automatic logic seq_last(input logic [2:0] o, input logic [1:0] s);
		return (s + 2'd1) >= seq_len(o);
	endfunction

	// ==========================================
	// status kept for software; reserved bits forced to zero
	// so software never sees noise from them
	function automatic logic [7:0] keep_status(input logic [7:0] raw);
		logic [7:0] k;
		k = 8'h00;
		k[flkc_pkg::ST_READY]   = raw[flkc_pkg::ST_READY];
		k[flkc_pkg::ST_ESUSP]   = raw[flkc_pkg::ST_ESUSP];
		k[flkc_pkg::ST_CLR_ERR] = raw[flkc_pkg::ST_CLR_ERR];
		k[flkc_pkg::ST_SET_ERR] = raw[flkc_pkg::ST_SET_ERR];
		k[flkc_pkg::ST_WSUSP]   = raw[flkc_pkg::ST_WSUSP];
		k[flkc_pkg::ST_PROT]    = raw[flkc_pkg::ST_PROT];
		return k;
	endfunction

	assign cmd_byte = seq_byte(op, step);
	// a start is a control write of a nonzero operation while idle
	assign start    = (state == S_IDLE) && reg_wr && !busy
	                  && (reg_addr == flkc_pkg::REG_CTRL) && (reg_wdata[2:0] != 3'h0);

	// ==========================================
	// command capture from the local port
	// writes while busy are dropped; software polls STATUS before a new order
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			op     <= 3'h0;
			target <= 20'h0_0000;
		end else if (reg_wr && !busy) begin
			if (reg_addr == flkc_pkg::REG_CTRL) begin
				op <= reg_wdata[2:0];
			end else if (reg_addr == flkc_pkg::REG_ADDR) begin
				target <= reg_wdata[19:0];
			end
		end
	end

	// ==========================================
	// sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= S_IDLE;
			busy  <= 1'b0;
			step  <= 2'd0;
			tcnt  <= 4'h0;
			polls <= 16'h0000;
		end else begin
			case (state)
				S_IDLE: begin
					if (start) begin
						busy  <= 1'b1;
						step  <= 2'd0;
						polls <= 16'h0000;
						tcnt  <= flkc_pkg::PULSE_CYC;
						state <= S_WR_ASSERT;
					end
				end
				S_WR_ASSERT: begin
					if (tcnt == 4'h1) begin
						tcnt  <= flkc_pkg::GAP_CYC;
						state <= S_WR_GAP;
					end else begin
						tcnt <= tcnt - 4'h1;
					end
				end
				S_WR_GAP: begin
					if (tcnt == 4'h1) begin
						if (!seq_last(op, step)) begin
							step  <= step + 2'd1;
							tcnt  <= flkc_pkg::PULSE_CYC;
							state <= S_WR_ASSERT;
						end else if (seq_polls(op)) begin
							// the flash already answers status reads here
							tcnt  <= flkc_pkg::PULSE_CYC;
							state <= S_RD_ASSERT;
						end else begin
							busy  <= 1'b0;
							state <= S_IDLE;
						end
					end else begin
						tcnt <= tcnt - 4'h1;
					end
				end
				S_RD_ASSERT: begin
					if (tcnt == 4'h1) begin
						tcnt  <= flkc_pkg::GAP_CYC;
						state <= S_RD_GAP;
					end else begin
						tcnt <= tcnt - 4'h1;
					end
				end
				S_RD_GAP: begin
					// gap also covers synchroniser latency
					if (tcnt == 4'h1) begin
						state <= S_DECIDE;
					end else begin
						tcnt <= tcnt - 4'h1;
					end
				end
				S_DECIDE: begin
					// give up after the poll limit so a dead flash cannot hang software
					if (dq_sync[flkc_pkg::ST_READY] || polls == flkc_pkg::POLL_LIMIT) begin
						busy  <= 1'b0;
						state <= S_IDLE;
					end else begin
						polls <= polls + 16'h0001;
						tcnt  <= flkc_pkg::PULSE_CYC;
						state <= S_RD_ASSERT;
					end
				end
				default: begin
					state <= S_IDLE;
					busy  <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// outcome capture: bits 6..0 only taken once ready is seen
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result  <= 8'h00;
			done    <= 1'b0;
			timeout <= 1'b0;
		end else if (start) begin
			done    <= 1'b0;
			timeout <= 1'b0;
		end else if (state == S_WR_GAP && tcnt == 4'h1 && seq_last(op, step)
		             && !seq_polls(op)) begin
			// no poll for this operation: finished once its last write ends
			done <= 1'b1;
		end else if (state == S_DECIDE) begin
			if (dq_sync[flkc_pkg::ST_READY]) begin
				// reserved bits 3 and 0 read as zero
				result <= keep_status(dq_sync);
				done   <= 1'b1;
			end else if (polls == flkc_pkg::POLL_LIMIT) begin
				// flash never reported ready within the poll limit
				timeout <= 1'b1;
				done    <= 1'b1;
			end
		end
	end

	// ==========================================
	// flash pin drive; a write needs both enables low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ce_n    <= 1'b1;
			we_n    <= 1'b1;
			oe_n    <= 1'b1;
			dq_oe   <= 1'b0;
			dq_out  <= 16'h0000;
			fl_addr <= 20'h0_0000;
		end else begin
			// both enables rise on one edge; the flash takes the command at the first
			ce_n  <= !(state == S_WR_ASSERT || state == S_RD_ASSERT);
			we_n  <= !(state == S_WR_ASSERT);
			oe_n  <= !(state == S_RD_ASSERT);
			// data held through the gap as hold time after the strobe
			dq_oe <= (state == S_WR_ASSERT || state == S_WR_GAP);
			dq_out  <= {8'h00, cmd_byte};
			// block confirm must land inside the target block
			fl_addr <= target;
		end
	end

	// ==========================================
	// register read port, data one cycle after the strobe
	// reads have no side effects, so polling never disturbs a sequence
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= flkc_pkg::RESET_WORD;
		end else if (reg_rd) begin
			case (reg_addr)
				flkc_pkg::REG_CTRL:   reg_rdata <= {29'h0, op};
				flkc_pkg::REG_ADDR:   reg_rdata <= {12'h000, target};
				flkc_pkg::REG_STATUS: reg_rdata <= {29'h0, timeout, done, busy};
				// protect, set-error, clear-error interpreted by software
				flkc_pkg::REG_RESULT: reg_rdata <= {24'h00_0000, result};
				default:              reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

//--- logic/flkc_pkg.sv
// flkc_pkg: constants for the lock-bit configuration host controller.
// assumes a 100 MHz clock and a x16 flash with async bus pins.
package flkc_pkg;
	// ==========================================
	// flash commands
	localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
	localparam logic [7:0] CMD_BLOCK_CONF   = 8'h01;
	localparam logic [7:0] CMD_PERM_CONF    = 8'hf1;
	localparam logic [7:0] CMD_CLEAR_CONF   = 8'hd0;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
	// ==========================================
	// operation_status field positions
	localparam int ST_READY   = 7;
	localparam int ST_ESUSP   = 6;
	localparam int ST_CLR_ERR = 5;
	localparam int ST_SET_ERR = 4;
	localparam int ST_WSUSP   = 2;
	localparam int ST_PROT    = 1;
	// ==========================================
	// controller register map (word index on the local port)
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_ADDR    = 4'h1;
	localparam logic [3:0] REG_STATUS  = 4'h2;
	localparam logic [3:0] REG_RESULT  = 4'h3;
	localparam logic [2:0] OP_SET_BLOCK = 3'h1;
	localparam logic [2:0] OP_SET_PERM  = 3'h2;
	localparam logic [2:0] OP_CLEAR     = 3'h3;
	localparam logic [2:0] OP_CLR_STAT  = 3'h4;
	localparam logic [2:0] OP_ARRAY     = 3'h5;
	localparam logic [2:0] OP_POLL      = 3'h6;
	localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
	// ==========================================
	// bus timing
	localparam int T_PULSE_NS = 60;
	localparam int T_GAP_NS   = 40;
	localparam int CLK_NS     = 10;
	localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] GAP_CYC   = 4'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] POLL_LIMIT = 16'hffff;
endpackage

//--- logic/flkc_sync.sv
// flkc_sync: three-stage synchroniser for pin inputs with agree filter.
// assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module flkc_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// pins in, filtered out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// bits change only once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_out <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					sync_out[i] <= s3[i];
				end
			end
		end
	end
endmodule
